// >>> rtl/dwi_slave.sv
// Purpose: two-wire slave holding two 8-bit wiper registers
// Assumes: scl and sda from pins, sampled on clk through two flops
// Notes: wiper outputs drive an analog ladder outside this block
//
// Notes on behaviour
// - First byte is seven address bits then direction, high means read.
// - Fixed variant uses fixed address; other takes two bits from pins.
// - Matching device pulls data low in ninth pulse; others stay idle.
// - Write mode: instruction top bit selects channel one or two.
// - Instruction second bit is shutdown: open high end, wiper to low end.
// - Shutdown keeps stored wiper; release reapplies the stored setting.
// - New wiper values accepted in shutdown, latest applied on release.
// - Six low instruction bits are ignored.
// - After instruction, data byte is stored to selected channel wiper.
// - Each byte is eight bits MSB first plus one acknowledge pulse.
// - Data changes only while clock low except start and stop.
// - Read mode sends data right after address acknowledge.
// - Read returns wiper of channel chosen by latest instruction.
// - Further data bytes in a write update the selected wiper.
// - Read repeats selected wiper for every acknowledged byte.
// - Address 0101111 fixed, or 01011 plus both pin levels.
// - Power-on presets both wipers to code 128.
// - Each channel holds an 8-bit wiper, one of 256 taps.
`timescale 1ns/100ps
module dwi_slave #(
	parameter bit PIN_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addrPinHigh,
	input wire logic addrPinLow,
	output dwi_pkg::dwi_wiper_s wiperOne,
	output dwi_pkg::dwi_wiper_s wiperTwo,
	output logic shutdownBit,
	output logic channelSelectBit
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sclSync_r, sdaSync_r, apSync_r, apMeta_r;
	logic sclPrev_r, sdaPrev_r;
	// Two flops per pin, second stage and history read only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			apMeta_r <= 2'h0;
			apSync_r <= 2'h0;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			apMeta_r <= {addrPinHigh, addrPinLow};
			apSync_r <= apMeta_r;
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
		end
	end

	logic scl, sda, sclRise, sclFall, startSeen, stopSeen;
	assign scl = sclSync_r[1];
	assign sda = sdaSync_r[1];
	assign sclRise = scl & ~sclPrev_r;
	assign sclFall = ~scl & sclPrev_r;
	// Start and stop: data moves while clock high
	assign startSeen = scl & sclPrev_r & sdaPrev_r & ~sda;
	assign stopSeen = scl & sclPrev_r & ~sdaPrev_r & sda;

	// ----------------------------------------------------------------
	// Bit engine
	// ----------------------------------------------------------------
	dwi_pkg::dwi_state_e state_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] txByte_r;
	logic readMode_r, ackSlot_r, masterNak_r;
	logic [7:0] wiper1_r, wiper2_r;
	logic chan_r, shdn_r;
	logic [6:0] myAddr;
	logic [7:0] byteNow;

	// Own address from variant and pins
	assign myAddr = PIN_VARIANT ? {dwi_pkg::PIN_ADDR_TOP, apSync_r}
		: dwi_pkg::FIXED_ADDR;
	assign byteNow = {shift_r[6:0], sda};

	// Sequencing of bytes and acknowledge slots
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= dwi_pkg::DWI_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			readMode_r <= 1'b0;
			ackSlot_r <= 1'b0;
			masterNak_r <= 1'b0;
		end else if (startSeen) begin
			state_r <= dwi_pkg::DWI_ADDR;
			bitCnt_r <= 4'h0;
			ackSlot_r <= 1'b0;
			masterNak_r <= 1'b0;
		end else if (stopSeen) begin
			state_r <= dwi_pkg::DWI_IDLE;
			ackSlot_r <= 1'b0;
		end else if (sclRise && !ackSlot_r) begin
			// Sample on rising edge, data stable while high
			shift_r <= byteNow;
			bitCnt_r <= bitCnt_r + 4'h1;
		end else if (sclRise && ackSlot_r && readMode_r) begin
			masterNak_r <= sda;
		end else if (sclFall) begin
			if (!ackSlot_r && bitCnt_r == dwi_pkg::BYTE_BITS) begin
				bitCnt_r <= 4'h0;
				case (state_r)
					dwi_pkg::DWI_ADDR: begin
						if (shift_r[7:1] == myAddr) begin
							ackSlot_r <= 1'b1;
							readMode_r <= shift_r[0];
						end else begin
							state_r <= dwi_pkg::DWI_IGNORE;
						end
					end
					dwi_pkg::DWI_INSTR, dwi_pkg::DWI_WDATA: begin
						ackSlot_r <= 1'b1;
					end
					dwi_pkg::DWI_RDATA: begin
						ackSlot_r <= 1'b1;
					end
					default: begin
						ackSlot_r <= 1'b0;
					end
				endcase
			end else if (ackSlot_r) begin
				ackSlot_r <= 1'b0;
				case (state_r)
					dwi_pkg::DWI_ADDR: begin
						state_r <= readMode_r ? dwi_pkg::DWI_RDATA
							: dwi_pkg::DWI_INSTR;
					end
					dwi_pkg::DWI_INSTR: begin
						state_r <= dwi_pkg::DWI_WDATA;
					end
					dwi_pkg::DWI_RDATA: begin
						if (masterNak_r) begin
							state_r <= dwi_pkg::DWI_IGNORE;
						end
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Instruction and wiper storage
	// ----------------------------------------------------------------
	logic byteDone;
	assign byteDone = sclFall && !ackSlot_r && bitCnt_r == dwi_pkg::BYTE_BITS
		&& !startSeen && !stopSeen;

	// Channel and shutdown, low six bits dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chan_r <= dwi_pkg::CHANNEL_PRESET;
			shdn_r <= dwi_pkg::SHUTDOWN_PRESET;
		end else if (byteDone && state_r == dwi_pkg::DWI_INSTR) begin
			chan_r <= shift_r[dwi_pkg::CHAN_POS];
			shdn_r <= shift_r[dwi_pkg::SHDN_POS];
		end
	end

	// Wiper registers, written in or out of shutdown
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wiper1_r <= dwi_pkg::WIPER_PRESET;
			wiper2_r <= dwi_pkg::WIPER_PRESET;
		end else if (byteDone && state_r == dwi_pkg::DWI_WDATA) begin
			if (!chan_r) begin
				wiper1_r <= shift_r;
			end else begin
				wiper2_r <= shift_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Data line drive
	// ----------------------------------------------------------------
	// Acknowledge low, or read data MSB first, changed on clock fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdaOe <= 1'b0;
			txByte_r <= 8'h00;
		end else if (startSeen || stopSeen) begin
			sdaOe <= 1'b0;
		end else if (sclFall) begin
			if (byteDone && state_r != dwi_pkg::DWI_RDATA
					&& state_r != dwi_pkg::DWI_IGNORE
					&& state_r != dwi_pkg::DWI_IDLE
					&& (state_r != dwi_pkg::DWI_ADDR
					|| shift_r[7:1] == myAddr)) begin
				sdaOe <= 1'b1;
			end else if (ackSlot_r && (readMode_r && !masterNak_r)
					&& (state_r == dwi_pkg::DWI_ADDR
					|| state_r == dwi_pkg::DWI_RDATA)) begin
				// Load selected wiper again for each byte
				txByte_r <= {(chan_r ? wiper2_r[6:0] : wiper1_r[6:0]), 1'b0};
				sdaOe <= chan_r ? !wiper2_r[7] : !wiper1_r[7];
			end else if (state_r == dwi_pkg::DWI_RDATA && !ackSlot_r
					&& bitCnt_r != dwi_pkg::BYTE_BITS) begin
				sdaOe <= !txByte_r[7];
				txByte_r <= {txByte_r[6:0], 1'b0};
			end else begin
				sdaOe <= 1'b0;
			end
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Wiper outputs
	// ----------------------------------------------------------------
	// Applied code is zero in shutdown, stored value kept
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wiperOne <= {dwi_pkg::WIPER_PRESET, dwi_pkg::WIPER_PRESET};
			wiperTwo <= {dwi_pkg::WIPER_PRESET, dwi_pkg::WIPER_PRESET};
			shutdownBit <= dwi_pkg::SHUTDOWN_PRESET;
			channelSelectBit <= dwi_pkg::CHANNEL_PRESET;
		end else begin
			wiperOne <= {wiper1_r, shdn_r ? 8'h00 : wiper1_r};
			wiperTwo <= {wiper2_r, shdn_r ? 8'h00 : wiper2_r};
			shutdownBit <= shdn_r;
			channelSelectBit <= chan_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_WIPER_KEPT: assert property (@(posedge clk) disable iff (rst)
		$rose(shdn_r) |-> $stable(wiper1_r) && $stable(wiper2_r))
		else $error("Wiper changed on shutdown entry");
	AST_APPLY_SHDN: assert property (@(posedge clk) disable iff (rst)
		shdn_r |=> wiperOne.applied == 8'h00)
		else $error("Applied code not zero in shutdown");
	AST_REAPPLY: assert property (@(posedge clk) disable iff (rst)
		!shdn_r |=> wiperOne.applied == $past(wiper1_r))
		else $error("Stored wiper not applied");
	AST_NO_ACK_IGNORE: assert property (@(posedge clk) disable iff (rst)
		state_r == dwi_pkg::DWI_IGNORE && !startSeen |=> !sdaOe)
		else $error("Drive while ignoring bus");
	AST_INSTR_ONLY: assert property (@(posedge clk) disable iff (rst)
		!(byteDone && state_r == dwi_pkg::DWI_INSTR) |=> $stable(chan_r))
		else $error("Channel changed without instruction");
	AST_ACK_NINTH: assert property (@(posedge clk) disable iff (rst)
		byteDone && state_r == dwi_pkg::DWI_ADDR && shift_r[7:1] == myAddr
		|=> sdaOe && ackSlot_r)
		else $error("Missing address acknowledge");
	AST_WIPER_WRITE: assert property (@(posedge clk) disable iff (rst)
		byteDone && state_r == dwi_pkg::DWI_WDATA && !chan_r
		|=> wiper1_r == $past(shift_r))
		else $error("Data byte not stored");
	AST_STOP_IDLE: assert property (@(posedge clk) disable iff (rst)
		stopSeen && !startSeen |=> state_r == dwi_pkg::DWI_IDLE && !sdaOe)
		else $error("Stop not honoured");
	AST_DRIVE_LOW_ONLY: assert property (@(posedge clk) disable iff (rst)
		sdaOe && !sclFall && !startSeen && !stopSeen |=> sdaOe || $past(sclFall)
		|| $past(startSeen) || $past(stopSeen))
		else $error("Data changed while clock high");
endmodule

// >>> pkg/dwi_pkg.sv
// Purpose: constants and types for the dual wiper two-wire slave
// Assumes: one system clock, bus pins sampled through synchronisers
// Notes: address and preset values shared by design and bench
package dwi_pkg;
	// ----------------------------------------------------------------
	// Address and presets
	// ----------------------------------------------------------------
	localparam logic [6:0] FIXED_ADDR = 7'h2f;
	localparam logic [4:0] PIN_ADDR_TOP = 5'h0b;
	localparam logic [7:0] WIPER_PRESET = 8'h80;
	localparam logic SHUTDOWN_PRESET = 1'b0;
	localparam logic CHANNEL_PRESET = 1'b0;
	// Instruction byte field positions
	localparam int CHAN_POS = 7;
	localparam int SHDN_POS = 6;
	// Bits in a byte before the acknowledge slot
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Protocol states, Gray coded along the write path
	typedef enum logic [2:0] {
		DWI_IDLE = 3'b000,
		DWI_ADDR = 3'b001,
		DWI_INSTR = 3'b011,
		DWI_WDATA = 3'b010,
		DWI_RDATA = 3'b110,
		DWI_IGNORE = 3'b111
	} dwi_state_e;

	// Wiper outputs of one channel
	typedef struct packed {
		logic [7:0] wiper;
		logic [7:0] applied;
	} dwi_wiper_s;
endpackage

// >>> test/dwi_master.sv
// Purpose: behavioural two-wire bus master facing the wiper slave
// Assumes: bus clock half period of four system clocks (400 ns period)
// Notes: data drive 1 means released; clock stands high between frames
`timescale 1ns/100ps
module dwi_master (
	input wire logic clk,
	input wire logic sdaLine,
	output logic sclDrv,
	output logic sdaDrv
);
	// Bus idles released
	initial begin
		sclDrv = 1'b1;
		sdaDrv = 1'b1;
	end

	// Whole system clocks, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Start: data falls while clock high
	task automatic start();
		tick(1);
		sdaDrv = 1'b0;
		tick(4);
		sclDrv = 1'b0;
	endtask

	// Stop: data pulled low, then rises while clock high
	task automatic stop();
		tick(1);
		sdaDrv = 1'b0;
		tick(3);
		sclDrv = 1'b1;
		tick(4);
		sdaDrv = 1'b1;
		tick(4);
	endtask

	// One slot: data set while clock low, sampled at end of high
	task automatic bit_slot(input logic b, output logic s);
		tick(1);
		sdaDrv = b;
		tick(3);
		sclDrv = 1'b1;
		tick(4);
		s = sdaLine;
		sclDrv = 1'b0;
	endtask

	// Eight bits MSB first, then the slave's acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], s);
		end
		bit_slot(1'b1, ack);
	endtask

	// Eight bits in, then our acknowledge or not-acknowledge
	task automatic recv_byte(input logic ackBit, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, s);
			b[i] = s;
		end
		bit_slot(ackBit, s);
	endtask
endmodule

// >>> test/tb.sv
// Purpose: self-checking bench for the dual wiper two-wire slave
// Assumes: pin variant, strap pins driven by the bench, plus a fixed
//          variant on the same bus
// Notes: expected codes worked out from the instruction fields
`timescale 1ns/100ps
module tb;
	logic clk, rst, sclBus, mSda, sdaOut, sdaOe, pinHigh, pinLow;
	logic shutdownBit, channelSelectBit, fixOut, fixOe;
	dwi_pkg::dwi_wiper_s wiperOne, wiperTwo, fixWiper;
	wire logic sdaBus;
	int failures, checked;

	// Wired-AND data line, pulled up
	assign sdaBus = mSda & ~(sdaOe & ~sdaOut) & ~(fixOe & ~fixOut);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	dwi_master u_bm (.clk(clk), .sdaLine(sdaBus), .sclDrv(sclBus),
		.sdaDrv(mSda));

	dwi_slave #(.PIN_VARIANT(1'b1)) u_dut (.clk(clk), .rst(rst),
		.sclIn(sclBus), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addrPinHigh(pinHigh), .addrPinLow(pinLow), .wiperOne(wiperOne),
		.wiperTwo(wiperTwo), .shutdownBit(shutdownBit),
		.channelSelectBit(channelSelectBit));

	// Fixed address variant sharing the bus
	dwi_slave #(.PIN_VARIANT(1'b0)) u_fix (.clk(clk), .rst(rst),
		.sclIn(sclBus), .sdaIn(sdaBus), .sdaOut(fixOut), .sdaOe(fixOe),
		.addrPinHigh(pinHigh), .addrPinLow(pinLow), .wiperOne(fixWiper),
		.wiperTwo(), .shutdownBit(), .channelSelectBit());

	// Compare and count
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Write transfer: address, instruction, n data bytes (d0, then d1 for the rest)
	task automatic wr(input logic [7:0] a, ins, d0, d1, input int n,
		input logic expAck);
		logic ack;
		u_bm.start();
		u_bm.send_byte(a, ack);
		check("address ack", 16'(expAck), 16'(ack));
		u_bm.send_byte(ins, ack);
		check("instruction ack", 16'(expAck), 16'(ack));
		for (int i = 0; i < n; i++) begin
			u_bm.send_byte(i == 0 ? d0 : d1, ack);
			check("data ack", 16'(expAck), 16'(ack));
		end
		u_bm.stop();
	endtask

	// Read transfer: n bytes, last one not acknowledged
	task automatic rd(input logic [7:0] a, input logic [7:0] exp,
		input int n);
		logic ack;
		logic [7:0] b;
		u_bm.start();
		u_bm.send_byte(a, ack);
		check("read address ack", 16'h0000, 16'(ack));
		for (int i = 0; i < n; i++) begin
			u_bm.recv_byte(i == n - 1, b);
			check("read byte", 16'(exp), 16'(b));
		end
		u_bm.stop();
	endtask

	// Watchdog against a hung bus
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("BAD watchdog expected finish seen timeout");
		complete_run();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		pinHigh = 1'b1;
		pinLow = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check("wiper one", 16'h8080, wiperOne);
		check("wiper two", 16'h8080, wiperTwo);
		check("mode", 16'h0000, 16'({shutdownBit, channelSelectBit}));
		$display("reset test done");
		wr(8'h5c, 8'h3f, 8'h3c, 8'ha5, 2, 1'b0);
		check("wiper one", 16'ha5a5, wiperOne);
		check("wiper two", 16'h8080, wiperTwo);
		check("fixed wiper one", 16'h8080, fixWiper);
		$display("write test done");
		rd(8'h5d, 8'ha5, 2);
		$display("read test done");
		wr(8'h5c, 8'hc0, 8'h11, 8'h00, 1, 1'b0);
		check("wiper two", 16'h1100, wiperTwo);
		check("mode", 16'h0003, 16'({shutdownBit, channelSelectBit}));
		wr(8'h5c, 8'h80, 8'h00, 8'h00, 0, 1'b0);
		check("wiper two", 16'h1111, wiperTwo);
		check("wiper one", 16'ha5a5, wiperOne);
		rd(8'h5d, 8'h11, 1);
		$display("shutdown test done");
		wr(8'h5a, 8'h00, 8'h00, 8'h00, 1, 1'b1);
		check("fixed wiper one", 16'h8080, fixWiper);
		check("wiper one", 16'ha5a5, wiperOne);
		pinLow = 1'b1;
		wr(8'h5e, 8'h3f, 8'h42, 8'h00, 1, 1'b0);
		check("wiper one", 16'h4242, wiperOne);
		check("fixed wiper one", 16'h4242, fixWiper);
		$display("address test done");
		complete_run();
	end
endmodule
